// *** logic/fmr_pkg.sv ***
// shared types and constants of the fault monitor response block
package fmr_pkg;

  localparam int CW            = 12;
  localparam int CLK_PERIOD_NS = 40;
  localparam int OPAMP_FILT_NS = 10000;
  localparam int OT_FILT_NS    = 20000;
  localparam int GATE_FILT_NS  = 4000;
  localparam int DRAIN_PER0_NS = 1000;
  localparam int DRAIN_PER1_NS = 2000;
  localparam int DRAIN_PER2_NS = 4000;
  localparam int DRAIN_PER3_NS = 8000;
  localparam logic [3:0] DRAIN_THR_MAX = 4'hb;
  localparam logic [3:0] DRAIN_THR_RST = 4'h0;

  // least time, rounded up, never under one cycle
  function automatic logic [CW-1:0] fmr_ns_to_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    if (c < 1)
    begin
      c = 1;
    end
    return c[CW-1:0];
  endfunction : fmr_ns_to_cyc

  localparam logic [CW-1:0] OPAMP_FILT_CYC = fmr_ns_to_cyc(OPAMP_FILT_NS);
  localparam logic [CW-1:0] OT_FILT_CYC    = fmr_ns_to_cyc(OT_FILT_NS);
  localparam logic [CW-1:0] GATE_FILT_CYC  = fmr_ns_to_cyc(GATE_FILT_NS);
  localparam logic [CW-1:0] DRAIN_PER0_CYC = fmr_ns_to_cyc(DRAIN_PER0_NS);
  localparam logic [CW-1:0] DRAIN_PER1_CYC = fmr_ns_to_cyc(DRAIN_PER1_NS);
  localparam logic [CW-1:0] DRAIN_PER2_CYC = fmr_ns_to_cyc(DRAIN_PER2_NS);
  localparam logic [CW-1:0] DRAIN_PER3_CYC = fmr_ns_to_cyc(DRAIN_PER3_NS);

  typedef enum logic [2:0] {
    FMR_MODE_OFF  = 3'h0,
    FMR_MODE_FLAG = 3'h1,
    FMR_MODE_PRL  = 3'h2,
    FMR_MODE_PRE  = 3'h3,
    FMR_MODE_ALL  = 3'h4,
    FMR_MODE_HOLD = 3'h5
  } fmr_mode_t;

  typedef enum logic [2:0] {
    FMR_ST_IDLE  = 3'b001,
    FMR_ST_FAULT = 3'b010,
    FMR_ST_HELD  = 3'b100
  } fmr_state_t;

  typedef struct packed {
    logic high_w;
    logic high_v;
    logic high_u;
    logic low_w;
    logic low_v;
    logic low_u;
  } fmr_fet6_t;

  typedef struct packed {
    logic predrv;
    logic relay;
    logic cp;
  } fmr_stop_t;

  typedef struct packed {
    fmr_mode_t low_side_drain_response_mode;
    fmr_mode_t high_side_drain_response_mode;
    fmr_mode_t gate_over_response_mode;
  } fmr_fet_modes_t;

  typedef struct packed {
    fmr_fet6_t drain;
    fmr_fet6_t gate;
  } fmr_mon_en_t;

endpackage : fmr_pkg

// *** logic/fmr_filter.sv ***
// digital filter: output rises after input held high for limit cycles
`timescale 1ns/1ps
`default_nettype none
module fmr_filter
  import fmr_pkg::*;
(
  input  wire logic          core_clk,
  input  wire logic          nrst,
  input  wire logic          raw,
  input  wire logic [CW-1:0] limit,
  output logic               det
);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          det;
  } fmr_filt_st_t;

  fmr_filt_st_t st_reg;
  fmr_filt_st_t st_next;

  always_comb
  begin
    st_next = st_reg;
    if (!raw)
    begin
      st_next.cnt = '0;
      st_next.det = 1'b0;
    end
    else if (st_reg.cnt < limit)
    begin
      st_next.cnt = st_reg.cnt + 1'b1;
      st_next.det = (st_reg.cnt + 1'b1) >= limit;
    end
    else
    begin
      st_next.det = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign det = st_reg.det;

  AST_FILT_DROP: assert property (@(posedge core_clk) disable iff (!nrst)
    !raw |=> !det) else $error("filter output outlived its input");

endmodule : fmr_filter
`default_nettype wire

// *** logic/fmr_resp.sv ***
// latched status, deferred mode and shutdown request of one fault source
`timescale 1ns/1ps
`default_nettype none
module fmr_resp
  import fmr_pkg::*;
(
  input  wire logic      core_clk,
  input  wire logic      nrst,
  input  wire logic      det,
  input  wire fmr_mode_t mode_req,
  input  wire logic      clr,
  output logic           status,
  output fmr_stop_t      stop
);

  typedef struct packed {
    fmr_state_t st;
    fmr_mode_t  mode;
  } fmr_resp_st_t;

  fmr_resp_st_t st_reg;
  fmr_resp_st_t st_next;

  always_comb
  begin
    st_next = st_reg;
    stop    = '0;
    // new mode only once the fault is gone and cleared
    if (st_reg.st == FMR_ST_IDLE && !det)
    begin
      st_next.mode = mode_req;
    end
    case (st_reg.st)
      FMR_ST_IDLE:
      begin
        if (det && st_reg.mode != FMR_MODE_OFF)
        begin
          st_next.st = FMR_ST_FAULT;
        end
      end
      FMR_ST_FAULT:
      begin
        // clear requests ignored here
        if (!det)
        begin
          st_next.st = FMR_ST_HELD;
        end
      end
      FMR_ST_HELD:
      begin
        if (det)
        begin
          st_next.st = FMR_ST_FAULT;
        end
        else if (clr)
        begin
          st_next.st = FMR_ST_IDLE;
        end
      end
      default:
      begin
        st_next.st = FMR_ST_IDLE;
      end
    endcase
    // stops last only while the fault stands, except the latched mode
    if (st_reg.st == FMR_ST_FAULT)
    begin
      case (st_reg.mode)
        FMR_MODE_PRL:  stop = '{predrv: 1'b1, relay: 1'b1, cp: 1'b0};
        FMR_MODE_PRE:  stop = '{predrv: 1'b1, relay: 1'b0, cp: 1'b0};
        FMR_MODE_ALL:  stop = '{predrv: 1'b1, relay: 1'b1, cp: 1'b1};
        FMR_MODE_HOLD: stop = '{predrv: 1'b1, relay: 1'b1, cp: 1'b1};
        default:       stop = '0;
      endcase
    end
    else if (st_reg.st == FMR_ST_HELD && st_reg.mode == FMR_MODE_HOLD)
    begin
      stop = '{predrv: 1'b1, relay: 1'b1, cp: 1'b1};
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_reg <= '{st: FMR_ST_IDLE, mode: FMR_MODE_OFF};
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign status = (st_reg.st != FMR_ST_IDLE);

  AST_CLR_BLOCKED: assert property (@(posedge core_clk) disable iff (!nrst)
    (status && det) |=> status) else $error("status cleared in fault");
  AST_HOLD_KEEP: assert property (@(posedge core_clk) disable iff (!nrst)
    (status && st_reg.mode == FMR_MODE_HOLD) |-> (stop.cp && stop.predrv))
    else $error("latched mode released shutdown");
  AST_RESUME: assert property (@(posedge core_clk) disable iff (!nrst)
    (status && !det && $past(!det) && st_reg.mode != FMR_MODE_HOLD)
    |-> stop == '0) else $error("shutdown kept after cancel");
  AST_MODE_FROZEN: assert property (@(posedge core_clk) disable iff (!nrst)
    status |=> st_reg.mode == $past(st_reg.mode))
    else $error("mode changed while status set");
  AST_OFF_IGNORED: assert property (@(posedge core_clk) disable iff (!nrst)
    (!status && st_reg.mode == FMR_MODE_OFF) |=> !status)
    else $error("fault latched in mode off");

endmodule : fmr_resp
`default_nettype wire

// *** logic/fmr_top.sv ***
// fault response logic for opamp supply, overtemperature, drain and gate
// Overview of operation
// - opamp overvoltage held for filter time sets flag, pulls indicator low, except in mode 000
// - each fault source offers six host selectable response modes
// - opamp mode written during fault applies after cancel and clear
// - mode 101 keeps charge pump and pre-drivers off after cancel
// - modes 001 to 100 resume drive but keep status and indicator
// - opamp status clear ignored during fault, allowed after cancel
// - overtemperature past filter time sets flag, except in mode 000
// - overtemperature flag drops only below the lower cancel threshold
// - overtemperature mode change applies after cancel and clear
// - overtemperature status unclearable during fault, clearable after
// - drain fault reaction chosen by the fet response select setting
// - twelve drain thresholds and four periods, per switch side
// - phase shut down by drain fault stops further drain detection
// - drain detection disabled per channel by monitor enable
// - low side drain fault only while low drive input is high
// - high side drain fault only while high drive input is high
// - six gate overvoltage channels, each with own status bit
// - gate response cannot stop single channels; uses charge pump
// - gate detection enabled per channel by monitor enable
// - gate overvoltage past filter sets flag; mode 000 ignores it
// - gate mode change applies after cancel and channel clear
`timescale 1ns/1ps
`default_nettype none
module fmr_top
  import fmr_pkg::*;
(
  input  wire logic  core_clk,
  input  wire logic  nrst,
  input  wire logic  opamp_over_cmp,
  input  wire fmr_mode_t opamp_over_response_mode,
  input  wire logic  opamp_over_clear,
  input  wire logic  overtemp_above_upper,
  input  wire logic  overtemp_below_lower,
  input  wire fmr_mode_t overtemp_response_mode,
  input  wire logic  overtemp_clear,
  input  wire fmr_fet6_t drive_in,
  input  wire fmr_fet6_t drain_cmp,
  input  wire fmr_fet6_t gate_cmp,
  input  wire fmr_fet_modes_t fet_fault_response_select,
  input  wire fmr_mon_en_t    fet_monitor_channel_enable,
  input  wire logic [3:0] high_side_drain_threshold_select,
  input  wire logic [3:0] low_side_drain_threshold_select,
  input  wire logic [1:0] high_side_drain_period_select,
  input  wire logic [1:0] low_side_drain_period_select,
  input  wire fmr_fet6_t drain_clear,
  input  wire fmr_fet6_t gate_clear,
  output logic       opamp_over_status,
  output logic       overtemp_status,
  output fmr_fet6_t  drain_fault_status,
  output fmr_fet6_t  gate_fault_status_reg,
  output logic [3:0] high_side_drain_threshold,
  output logic [3:0] low_side_drain_threshold,
  output logic [2:0] predrv_en,
  output logic       relay_en,
  output logic       cp_en,
  output logic       fault_indicator_n
);

  typedef struct packed {
    logic       ot_det;
    logic [3:0] hs_thr;
    logic [3:0] ls_thr;
    logic [2:0] predrv_en;
    logic       relay_en;
    logic       cp_en;
    logic       ind_n;
  } fmr_top_st_t;

  fmr_top_st_t st_reg;
  fmr_top_st_t st_next;

  logic          op_det;
  logic          ot_filt;
  logic          op_status;
  logic          ot_status;
  fmr_stop_t     op_stop;
  fmr_stop_t     ot_stop;
  logic [5:0]    dr_raw;
  logic [5:0]    dr_det;
  logic [5:0]    dr_status;
  logic [5:0]    gt_raw;
  logic [5:0]    gt_det;
  logic [5:0]    gt_status;
  fmr_stop_t     dr_stop [6];
  fmr_stop_t     gt_stop [6];
  logic [2:0]    dr_phase_off;
  logic [CW-1:0] hs_limit;
  logic [CW-1:0] ls_limit;
  logic [5:0]    drv_v;
  logic [5:0]    dcmp_v;
  logic [5:0]    gcmp_v;
  logic [5:0]    den_v;
  logic [5:0]    gen_v;
  logic [5:0]    dclr_v;
  logic [5:0]    gclr_v;

  assign drv_v  = drive_in;
  assign dcmp_v = drain_cmp;
  assign gcmp_v = gate_cmp;
  assign den_v  = fet_monitor_channel_enable.drain;
  assign gen_v  = fet_monitor_channel_enable.gate;
  assign dclr_v = drain_clear;
  assign gclr_v = gate_clear;

  function automatic logic [CW-1:0] period_cyc(input logic [1:0] sel);
    case (sel)
      2'h0:    return DRAIN_PER0_CYC;
      2'h1:    return DRAIN_PER1_CYC;
      2'h2:    return DRAIN_PER2_CYC;
      default: return DRAIN_PER3_CYC;
    endcase
  endfunction : period_cyc

  assign hs_limit = period_cyc(high_side_drain_period_select);
  assign ls_limit = period_cyc(low_side_drain_period_select);

  fmr_filter u_op_filt (
    .core_clk (core_clk),
    .nrst     (nrst),
    .raw      (opamp_over_cmp),
    .limit    (OPAMP_FILT_CYC),
    .det      (op_det)
  );

  fmr_resp u_op_resp (
    .core_clk (core_clk),
    .nrst     (nrst),
    .det      (op_det),
    .mode_req (opamp_over_response_mode),
    .clr      (opamp_over_clear),
    .status   (op_status),
    .stop     (op_stop)
  );

  fmr_filter u_ot_filt (
    .core_clk (core_clk),
    .nrst     (nrst),
    .raw      (overtemp_above_upper),
    .limit    (OT_FILT_CYC),
    .det      (ot_filt)
  );

  fmr_resp u_ot_resp (
    .core_clk (core_clk),
    .nrst     (nrst),
    .det      (st_reg.ot_det),
    .mode_req (overtemp_response_mode),
    .clr      (overtemp_clear),
    .status   (ot_status),
    .stop     (ot_stop)
  );

  genvar i;
  generate
    for (i = 0; i < 6; i++)
    begin : g_fet
      // phase of channel i: low side u,v,w then high side u,v,w
      // a shut phase blocks new causes; the one that shut it stays seen,
      // so the phase is not re-enabled while its own short persists
      assign dr_raw[i] = dcmp_v[i] && drv_v[i] && den_v[i]
                         && (!dr_phase_off[i % 3]
                             || dr_stop[i].predrv);
      assign gt_raw[i] = gcmp_v[i] && gen_v[i];

      fmr_filter u_dr_filt (
        .core_clk (core_clk),
        .nrst     (nrst),
        .raw      (dr_raw[i]),
        .limit    ((i < 3) ? ls_limit : hs_limit),
        .det      (dr_det[i])
      );

      fmr_resp u_dr_resp (
        .core_clk (core_clk),
        .nrst     (nrst),
        .det      (dr_det[i]),
        .mode_req ((i < 3)
          ? fet_fault_response_select.low_side_drain_response_mode
          : fet_fault_response_select.high_side_drain_response_mode),
        .clr      (dclr_v[i]),
        .status   (dr_status[i]),
        .stop     (dr_stop[i])
      );

      fmr_filter u_gt_filt (
        .core_clk (core_clk),
        .nrst     (nrst),
        .raw      (gt_raw[i]),
        .limit    (GATE_FILT_CYC),
        .det      (gt_det[i])
      );

      fmr_resp u_gt_resp (
        .core_clk (core_clk),
        .nrst     (nrst),
        .det      (gt_det[i]),
        .mode_req (fet_fault_response_select.gate_over_response_mode),
        .clr      (gclr_v[i]),
        .status   (gt_status[i]),
        .stop     (gt_stop[i])
      );
    end
  endgenerate

  always_comb
  begin
    dr_phase_off = '0;
    for (int k = 0; k < 6; k++)
    begin
      if (dr_stop[k].predrv)
      begin
        dr_phase_off[k % 3] = 1'b1;
      end
    end
  end

  always_comb
  begin
    logic any_predrv;
    logic any_relay;
    logic any_cp;
    logic any_stat;
    st_next    = st_reg;
    any_stat   = op_status | ot_status | (|dr_status) | (|gt_status);
    any_predrv = op_stop.predrv | ot_stop.predrv;
    any_relay  = op_stop.relay | ot_stop.relay;
    any_cp     = op_stop.cp | ot_stop.cp;
    for (int k = 0; k < 6; k++)
    begin
      any_relay = any_relay | dr_stop[k].relay | gt_stop[k].relay;
      any_cp    = any_cp | dr_stop[k].cp;
      // gate faults reach the drivers only through the pump
      any_cp    = any_cp | gt_stop[k].cp | gt_stop[k].predrv;
    end
    // overtemperature with hysteresis
    if (ot_filt)
    begin
      st_next.ot_det = 1'b1;
    end
    else if (overtemp_below_lower)
    begin
      st_next.ot_det = 1'b0;
    end
    st_next.hs_thr = (high_side_drain_threshold_select > DRAIN_THR_MAX)
                     ? DRAIN_THR_MAX : high_side_drain_threshold_select;
    st_next.ls_thr = (low_side_drain_threshold_select > DRAIN_THR_MAX)
                     ? DRAIN_THR_MAX : low_side_drain_threshold_select;
    st_next.predrv_en = ~({3{any_predrv}} | dr_phase_off);
    st_next.relay_en  = !any_relay;
    st_next.cp_en     = !any_cp;
    st_next.ind_n = !any_stat;
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_reg <= '{ot_det: 1'b0, hs_thr: DRAIN_THR_RST, ls_thr: DRAIN_THR_RST,
                 predrv_en: 3'h7, relay_en: 1'b1, cp_en: 1'b1,
                 ind_n: 1'b1};
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign opamp_over_status         = op_status;
  assign overtemp_status           = ot_status;
  assign drain_fault_status        = dr_status;
  assign gate_fault_status_reg     = gt_status;
  assign high_side_drain_threshold = st_reg.hs_thr;
  assign low_side_drain_threshold  = st_reg.ls_thr;
  assign predrv_en                 = st_reg.predrv_en;
  assign relay_en                  = st_reg.relay_en;
  assign cp_en                     = st_reg.cp_en;
  assign fault_indicator_n         = st_reg.ind_n;

  AST_IND: assert property (@(posedge core_clk) disable iff (!nrst)
    (op_status || ot_status || dr_status != '0 || gt_status != '0)
    |=> !fault_indicator_n) else $error("indicator high with status");
  AST_OT_HYST: assert property (@(posedge core_clk) disable iff (!nrst)
    (st_reg.ot_det && !overtemp_below_lower) |=> st_reg.ot_det)
    else $error("overtemperature dropped above lower limit");
  AST_DRAIN_DRIVE: assert property (@(posedge core_clk) disable iff (!nrst)
    ($past(dr_status) == '0 && dr_status != '0)
    |-> ((dr_status & $past(drv_v, 2)) != '0))
    else $error("drain fault without drive input");
  AST_THR_RANGE: assert property (@(posedge core_clk) disable iff (!nrst)
    (high_side_drain_threshold <= DRAIN_THR_MAX)
    && (low_side_drain_threshold <= DRAIN_THR_MAX))
    else $error("drain threshold code out of range");

endmodule : fmr_top
`default_nettype wire

// *** tb/fmr_bridge_model.sv ***
// behavioural model of the external mosfet bridge comparators
`timescale 1ns/1ps
`default_nettype none
module fmr_bridge_model
  import fmr_pkg::*;
(
  input  wire fmr_fet6_t short_cmd,
  input  wire fmr_fet6_t gate_over_cmd,
  output fmr_fet6_t      drain_cmp,
  output fmr_fet6_t      gate_cmp
);
  // a shorted switch shows high drain voltage whether driven or not
  assign drain_cmp = short_cmd;
  assign gate_cmp  = gate_over_cmd;
endmodule : fmr_bridge_model
`default_nettype wire

// *** tb/fmr_top_test.sv ***
// self-checking bench of the fault monitor response block
`timescale 1ns/1ps
`default_nettype none
module fmr_top_test
  import fmr_pkg::*;
;
  // mode, run p/r/c/ind in fault, run p/r/c/ind after cancel, status in fault
  typedef struct packed {
    fmr_mode_t  mode;
    logic [2:0] dp;
    logic [2:0] drci;
    logic [2:0] ap;
    logic [2:0] arci;
    logic       as;
  } fmr_tb_row_t;
  localparam logic [15:0] ROWS [6] = '{16'h1ffe, 16'h3f7d, 16'h417d,
                                       16'h637d, 16'h807d, 16'ha001};
  logic           core_clk = 1'b0;
  logic           nrst     = 1'b0;
  logic           op_cmp, op_clr, ot_up, ot_low, ot_clr;
  fmr_mode_t      op_mode, ot_mode;
  fmr_fet6_t      drive_in, drain_cmp, gate_cmp, drain_clear, gate_clear;
  fmr_fet6_t      short_cmd, gate_over_cmd, drain_st, gate_st;
  fmr_fet_modes_t fet_sel;
  fmr_mon_en_t    mon_en;
  logic [3:0]     hs_sel, ls_sel, hs_thr, ls_thr;
  logic [1:0]     hs_per, ls_per;
  logic           op_st, ot_st, relay_en, cp_en, fault_indicator_n;
  logic [2:0]     predrv_en;
  fmr_tb_row_t    r;
  int             err_count   = 0;
  int             checks_done = 0;

  always #20 core_clk = ~core_clk;

  fmr_bridge_model bridge (
    .short_cmd     (short_cmd),
    .gate_over_cmd (gate_over_cmd),
    .drain_cmp     (drain_cmp),
    .gate_cmp      (gate_cmp)
  );

  fmr_top uut (
    .core_clk                         (core_clk),
    .nrst                             (nrst),
    .opamp_over_cmp                   (op_cmp),
    .opamp_over_response_mode         (op_mode),
    .opamp_over_clear                 (op_clr),
    .overtemp_above_upper             (ot_up),
    .overtemp_below_lower             (ot_low),
    .overtemp_response_mode           (ot_mode),
    .overtemp_clear                   (ot_clr),
    .drive_in                         (drive_in),
    .drain_cmp                        (drain_cmp),
    .gate_cmp                         (gate_cmp),
    .fet_fault_response_select        (fet_sel),
    .fet_monitor_channel_enable       (mon_en),
    .high_side_drain_threshold_select (hs_sel),
    .low_side_drain_threshold_select  (ls_sel),
    .high_side_drain_period_select    (hs_per),
    .low_side_drain_period_select     (ls_per),
    .drain_clear                      (drain_clear),
    .gate_clear                       (gate_clear),
    .opamp_over_status                (op_st),
    .overtemp_status                  (ot_st),
    .drain_fault_status               (drain_st),
    .gate_fault_status_reg            (gate_st),
    .high_side_drain_threshold        (hs_thr),
    .low_side_drain_threshold         (ls_thr),
    .predrv_en                        (predrv_en),
    .relay_en                         (relay_en),
    .cp_en                            (cp_en),
    .fault_indicator_n                (fault_indicator_n)
  );

  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask : tick

  task automatic chk1(input string what, input logic seen, input logic exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk1

  task automatic chkv(input string what, input logic [5:0] seen,
                      input logic [5:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chkv

  task automatic op_clear();
    op_clr = 1'b1;
    tick(1);
    op_clr = 1'b0;
    tick(2);
  endtask : op_clear

  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
    begin
      $display("TB: PASS");
    end
    else
    begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test

  // watchdog
  initial
  begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    finish_test();
  end

  initial
  begin
    {op_cmp, op_clr, ot_up, ot_low, ot_clr} = 5'h00;
    op_mode       = FMR_MODE_OFF;
    ot_mode       = FMR_MODE_OFF;
    drive_in      = 6'h00;
    short_cmd     = 6'h00;
    gate_over_cmd = 6'h00;
    drain_clear   = 6'h00;
    gate_clear    = 6'h00;
    fet_sel       = {FMR_MODE_PRE, FMR_MODE_PRE, FMR_MODE_PRE};
    mon_en        = {6'h3b, 6'h3d};
    hs_sel        = 4'hf;
    ls_sel        = 4'h5;
    hs_per        = 2'h0;
    ls_per        = 2'h1;
    tick(2);
    nrst = 1'b1;
    tick(1);
    chkv("reset_enables", {predrv_en, relay_en, cp_en, op_st}, 6'h3e);
    chk1("reset_ind", fault_indicator_n, 1'b1);
    // opamp overvoltage through every response mode
    for (int i = 0; i < 6; i++)
    begin
      r = fmr_tb_row_t'(ROWS[i]);
      op_mode = r.mode;
      tick(2);
      op_cmp = 1'b1;
      tick(250);
      chk1("op_status_early", op_st, 1'b0);
      tick(1);
      chk1("op_status", op_st, r.as);
      tick(1);
      chkv("op_run_fault", {predrv_en, relay_en, cp_en, fault_indicator_n},
           {r.dp, r.drci});
      op_clear();
      chk1("op_clear_refused", op_st, r.as);
      op_cmp = 1'b0;
      tick(3);
      chkv("op_run_after", {predrv_en, relay_en, cp_en, fault_indicator_n},
           {r.ap, r.arci});
      op_clear();
      chkv("op_cleared", {1'b0, predrv_en, op_st, fault_indicator_n},
           6'h1d);
    end
    // mode change during fault is deferred
    op_mode = FMR_MODE_FLAG;
    tick(2);
    op_cmp = 1'b1;
    tick(260);
    op_mode = FMR_MODE_ALL;
    tick(3);
    chk1("op_mode_held", cp_en, 1'b1);
    op_cmp = 1'b0;
    tick(3);
    op_clear();
    op_cmp = 1'b1;
    tick(260);
    chk1("op_mode_applied", cp_en, 1'b0);
    op_cmp = 1'b0;
    tick(3);
    op_clear();
    // overtemperature with hysteresis
    ot_mode = FMR_MODE_PRE;
    tick(2);
    ot_up = 1'b1;
    tick(503);
    chk1("ot_status", ot_st, 1'b1);
    chkv("ot_predrv", {2'h0, predrv_en, fault_indicator_n}, 6'h00);
    ot_up = 1'b0;
    tick(3);
    ot_clr = 1'b1;
    tick(1);
    ot_clr = 1'b0;
    tick(2);
    chk1("ot_clear_refused", ot_st, 1'b1);
    chkv("ot_between", {3'h0, predrv_en}, 6'h00);
    ot_low = 1'b1;
    tick(3);
    chkv("ot_cancel", {2'h0, predrv_en, fault_indicator_n}, 6'h0e);
    ot_clr = 1'b1;
    tick(1);
    ot_clr = 1'b0;
    tick(2);
    chkv("ot_cleared", {4'h0, ot_st, fault_indicator_n}, 6'h01);
    ot_low = 1'b0;
    // drain thresholds, periods, gating and phase shutdown
    chkv("hs_thr", {2'h0, hs_thr}, 6'h0b);
    chkv("ls_thr", {2'h0, ls_thr}, 6'h05);
    drive_in  = 6'h0d;
    short_cmd = 6'h07;
    tick(40);
    chkv("drain_early", drain_st, 6'h00);
    tick(20);
    chkv("drain_low", drain_st, 6'h01);
    chk1("drain_phase", $countones(predrv_en) == 2, 1'b1);
    drive_in  = 6'h1d;
    short_cmd = 6'h1f;
    tick(30);
    chkv("drain_high", drain_st, 6'h11);
    chk1("drain_ind", fault_indicator_n, 1'b0);
    drive_in  = 6'h00;
    short_cmd = 6'h00;
    tick(3);
    drain_clear = 6'h3f;
    tick(1);
    drain_clear = 6'h00;
    tick(2);
    chkv("drain_cleared", {drain_st[5:3], predrv_en}, 6'h07);
    // gate overvoltage per channel, charge pump stop, deferred mode
    gate_over_cmd = 6'h22;
    tick(105);
    chkv("gate_status", gate_st, 6'h20);
    chkv("gate_stop", {2'h0, predrv_en, cp_en}, 6'h0e);
    fet_sel = {FMR_MODE_PRE, FMR_MODE_PRE, FMR_MODE_FLAG};
    tick(3);
    chk1("gate_mode_held", cp_en, 1'b0);
    gate_over_cmd = 6'h00;
    tick(3);
    chkv("gate_cancel", {4'h0, cp_en, fault_indicator_n}, 6'h02);
    gate_clear = 6'h3f;
    tick(1);
    gate_clear = 6'h00;
    tick(2);
    chkv("gate_cleared", gate_st, 6'h00);
    chk1("gate_ind", fault_indicator_n, 1'b1);
    gate_over_cmd = 6'h20;
    tick(105);
    chkv("gate_mode_new", {gate_st[5:1], cp_en}, 6'h21);
    finish_test();
  end
endmodule : fmr_top_test
`default_nettype wire
